/* File: mitc_indexer_chopper.sv */
// microstep indexer with per-winding pwm current chopper and apb registers
`timescale 1ns/1ps

module mitc_indexer_chopper #(
    parameter int WAKE_CYC = mitc_pkg::WAKE_CYC_DEF
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_step,
    input wire logic i_dir,
    input wire logic [2:0] i_resolution_select,
    input wire logic i_home_return_n,
    input wire logic i_low_power_request_n,
    input wire logic i_decay_level,
    input wire logic i_decay_driven,
    input wire logic [1:0][7:0] i_winding_sense_pin,
    input wire logic [1:0][7:0] i_winding_reference_in,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output mitc_pkg::mitc_bridge_s [1:0] o_bridge,
    output mitc_pkg::mitc_dac_s [1:0] o_dac,
    output logic o_at_home_n
);
    import mitc_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [6:0] step_size(input logic [2:0] res);
        unique case (res)
            3'h0: step_size = 7'h20;
            3'h1: step_size = 7'h10;
            3'h2: step_size = 7'h08;
            3'h3: step_size = 7'h04;
            3'h4: step_size = 7'h02;
            default: step_size = 7'h01;
        endcase
    endfunction

    function automatic logic [6:0] next_idx(input logic [6:0] idx, input logic [2:0] res,
                                            input logic fwd);
        logic [6:0] s;
        logic [6:0] ofs;
        logic [6:0] rel;
        logic [6:0] base;
        s = step_size(res);
        ofs = (res == 3'h0) ? FULL_OFS : 7'h00;
        rel = idx - ofs;
        base = rel & ~(s - 7'h01);
        if (fwd) begin
            next_idx = base + s + ofs;
        end else if (base == rel) begin
            next_idx = base - s + ofs;
        end else begin
            next_idx = base + ofs;
        end
    endfunction

    function automatic mitc_dac_s wind_level(input logic [6:0] idx, input logic cosine);
        logic [1:0] q;
        logic [5:0] k;
        logic [5:0] kc;
        mitc_dac_s r;
        q = idx[6:5];
        k = {1'b0, idx[4:0]};
        kc = QTR_STATES - k;
        if (cosine) begin
            q = q + 2'h1;
        end
        r.pct = q[0] ? SINE_TBL[kc] : SINE_TBL[k];
        r.neg = q[1] & (r.pct != 7'h00);
        wind_level = r;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == CTRL_ADDR) || (a == STATUS_ADDR) || (a == DAC_ADDR);
    endfunction

    // ----------------------------------------
    // input capture and wake
    // ----------------------------------------
    logic step_d_reg;
    logic step_edge;
    logic step_take;
    logic [31:0] wake_cnt_reg;
    logic wake_done_reg;
    mitc_decay_e decay_reg;
    logic home_req_reg;
    logic bridge_en_reg;
    logic bridge_active;

    // pins are taken as driven except decay; an open decay pin is seen as mixed here
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_d_reg <= 1'b0;
        end else begin
            step_d_reg <= i_step;
        end
    end
    assign step_edge = i_step & ~step_d_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_cnt_reg <= 32'h0;
            wake_done_reg <= 1'b0;
        end else if (!i_low_power_request_n) begin
            wake_cnt_reg <= 32'h0;
            wake_done_reg <= 1'b0;
        end else if (!wake_done_reg) begin
            wake_cnt_reg <= wake_cnt_reg + 32'h1;
            wake_done_reg <= (wake_cnt_reg >= 32'(WAKE_CYC - 1));
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            decay_reg <= DECAY_MIXED;
        end else if (!i_decay_driven) begin
            decay_reg <= DECAY_MIXED;
        end else begin
            decay_reg <= i_decay_level ? DECAY_FAST : DECAY_SLOW;
        end
    end

    assign step_take = step_edge & i_home_return_n & wake_done_reg & ~home_req_reg;
    assign bridge_active = bridge_en_reg & i_low_power_request_n;

    // ----------------------------------------
    // indexer
    // ----------------------------------------
    logic [6:0] idx_reg;
    logic [6:0] idx_next;
    logic [1:0] dec_reg;

    assign idx_next = next_idx(idx_reg, i_resolution_select, i_dir);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_reg <= HOME_IDX;
        end else if (!i_home_return_n || home_req_reg) begin
            idx_reg <= HOME_IDX;
        end else if (step_take) begin
            idx_reg <= idx_next;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_at_home_n <= 1'b0;
        end else begin
            o_at_home_n <= (idx_reg != HOME_IDX);
        end
    end

    // ----------------------------------------
    // pwm period counter
    // ----------------------------------------
    logic [CNT_W-1:0] pwm_cnt_reg;
    logic period_end;
    logic past_blank;
    logic mixed_late;

    assign period_end = (pwm_cnt_reg == CNT_W'(PWM_CYC - 1));
    assign past_blank = (pwm_cnt_reg >= CNT_W'(BLANK_CYC));
    assign mixed_late = (pwm_cnt_reg >= CNT_W'(MIXED_CYC - 1));

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_cnt_reg <= '0;
        end else if (period_end) begin
            pwm_cnt_reg <= '0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + CNT_W'(1);
        end
    end

    // ----------------------------------------
    // per-winding dac, comparator and chopper
    // ----------------------------------------
    mitc_chop_e chop_st [2];
    logic [1:0] trip;
    logic [1:0] near_zero;

    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : g_wind
            mitc_dac_s lvl_now;
            mitc_dac_s lvl_new;
            logic [16:0] sense_scaled;
            logic [16:0] ref_scaled;

            assign lvl_now = wind_level(idx_reg, (w == 0));
            assign lvl_new = wind_level(idx_next, (w == 0));
            assign sense_scaled = 17'(i_winding_sense_pin[w]) * SENSE_SCALE;
            assign ref_scaled = 17'(i_winding_reference_in[w]) * 17'(o_dac[w].pct);
            assign trip[w] = (sense_scaled >= ref_scaled);
            assign near_zero[w] = (i_winding_sense_pin[w] <= ZERO_SENSE);

            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_dac[w] <= '0;
                end else begin
                    o_dac[w] <= lvl_now;
                end
            end

            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    dec_reg[w] <= 1'b0;
                end else if (!i_home_return_n || home_req_reg) begin
                    dec_reg[w] <= 1'b0;
                end else if (step_take) begin
                    dec_reg[w] <= (lvl_new.pct < lvl_now.pct);
                end
            end

            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    chop_st[w] <= CH_OFF;
                end else if (!bridge_active) begin
                    chop_st[w] <= CH_OFF;
                end else if (period_end) begin
                    chop_st[w] <= CH_DRIVE;
                end else begin
                    unique case (chop_st[w])
                        CH_DRIVE: begin
                            if (past_blank && trip[w]) begin
                                if (decay_reg == DECAY_FAST) begin
                                    chop_st[w] <= CH_FAST;
                                end else if (decay_reg == DECAY_MIXED && dec_reg[w]) begin
                                    chop_st[w] <= mixed_late ? CH_SLOW : CH_FAST;
                                end else begin
                                    chop_st[w] <= CH_SLOW;
                                end
                            end
                        end
                        CH_FAST: begin
                            if (near_zero[w]) begin
                                chop_st[w] <= CH_OFF;
                            end else if (decay_reg == DECAY_MIXED && mixed_late) begin
                                chop_st[w] <= CH_SLOW;
                            end
                        end
                        CH_SLOW: chop_st[w] <= CH_SLOW;
                        CH_OFF: chop_st[w] <= CH_OFF;
                    endcase
                end
            end

            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_bridge[w] <= '0;
                end else begin
                    unique case (chop_st[w])
                        CH_DRIVE: o_bridge[w] <= o_dac[w].neg ? 4'b0110 : 4'b1001;
                        CH_FAST: o_bridge[w] <= o_dac[w].neg ? 4'b1001 : 4'b0110;
                        CH_SLOW: o_bridge[w] <= 4'b0101;
                        CH_OFF: o_bridge[w] <= 4'b0000;
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic apb_access;
    logic apb_done;

    assign apb_access = i_psel & i_penable & ~o_pready;
    assign apb_done = i_psel & i_penable & o_pready;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= apb_access;
            o_pslverr <= apb_access & ~addr_known(i_paddr);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0;
        end else if (apb_access && !i_pwrite) begin
            unique case (i_paddr)
                CTRL_ADDR: o_prdata <= {30'h0, bridge_en_reg, 1'b0};
                STATUS_ADDR: o_prdata <= {16'h0, chop_st[1], chop_st[0], dec_reg,
                                          wake_done_reg, decay_reg, idx_reg};
                DAC_ADDR: o_prdata <= {16'h0, o_dac[1], o_dac[0]};
                default: o_prdata <= 32'h0;
            endcase
        end else if (apb_done) begin
            o_prdata <= 32'h0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bridge_en_reg <= CTRL_BRIDGE_EN_RST;
            home_req_reg <= 1'b0;
        end else if (apb_done && i_pwrite && i_paddr == CTRL_ADDR) begin
            bridge_en_reg <= i_pwdata[CTRL_BRIDGE_EN_BIT];
            home_req_reg <= i_pwdata[CTRL_HOME_BIT];
        end else begin
            home_req_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    period_start_a: assert property (period_end && bridge_active
        |=> chop_st[0] == CH_DRIVE && chop_st[1] == CH_DRIVE)
        else $error("period did not start in drive");
    blank_hold_a: assert property (chop_st[0] == CH_DRIVE && !past_blank
        && !period_end && bridge_active |=> chop_st[0] == CH_DRIVE)
        else $error("drive ended inside blanking");
    trip_stop_a: assert property (chop_st[1] == CH_DRIVE && past_blank && trip[1]
        && !period_end && bridge_active |=> chop_st[1] != CH_DRIVE)
        else $error("trip did not stop drive");
    slow_lows_a: assert property (chop_st[0] == CH_SLOW |=> o_bridge[0] == 4'b0101)
        else $error("slow decay switches wrong");
    fast_zero_a: assert property (chop_st[0] == CH_FAST && near_zero[0] && !period_end
        && bridge_active |=> chop_st[0] == CH_OFF)
        else $error("fast decay not stopped near zero");
    mixed_late_a: assert property (chop_st[1] == CH_FAST && decay_reg == DECAY_MIXED
        && mixed_late && !near_zero[1] && !period_end && bridge_active
        |=> chop_st[1] == CH_SLOW) else $error("mixed decay did not go slow");
    rising_slow_a: assert property (chop_st[0] == CH_DRIVE && past_blank && trip[0]
        && decay_reg == DECAY_MIXED && !dec_reg[0] && !period_end && bridge_active
        |=> chop_st[0] == CH_SLOW) else $error("rising current not slow");
    home_hold_a: assert property (!i_home_return_n |=> idx_reg == HOME_IDX)
        else $error("index left home during reset");
    fine_step_a: assert property (step_take && i_dir && i_resolution_select == 3'h5
        && i_home_return_n |=> idx_reg == $past(idx_reg) + 7'h01)
        else $error("fine forward step wrong");
    full_grid_a: assert property (step_take && i_resolution_select == 3'h0
        && i_home_return_n |=> idx_reg[4:0] == 5'h10)
        else $error("full step off the 45 degree grid");
    wake_block_a: assert property ($rose(i_low_power_request_n)
        |-> !wake_done_reg [*2]) else $error("steps enabled right after wake");
endmodule

/* File: mitc_pkg.sv */
// package: constants and types for the microstep indexer and chopper
package mitc_pkg;
    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_MHZ = 100;
    localparam int PWM_HZ = 30_000;
    localparam int PWM_CYC = CLK_HZ / PWM_HZ;
    localparam int BLANK_NS = 3750;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int MIXED_PCT = 75;
    localparam int MIXED_CYC = PWM_CYC * MIXED_PCT / 100;
    localparam int WAKE_US = 1700;
    localparam int WAKE_CYC_DEF = WAKE_US * CLK_MHZ;
    localparam int CNT_W = 12;

    // ----------------------------------------
    // current sensing
    // ----------------------------------------
    localparam int SENSE_GAIN = 5;
    localparam int FULL_PCT = 100;
    localparam logic [16:0] SENSE_SCALE = 17'(SENSE_GAIN * FULL_PCT);
    localparam logic [7:0] ZERO_SENSE = 8'h01;

    // ----------------------------------------
    // indexer
    // ----------------------------------------
    localparam logic [6:0] HOME_IDX = 7'h10;
    localparam logic [6:0] FULL_OFS = 7'h10;
    localparam logic [5:0] QTR_STATES = 6'h20;
    localparam logic [6:0] SINE_TBL [0:32] = '{
        7'h00, 7'h05, 7'h0a, 7'h0f, 7'h14, 7'h18, 7'h1d, 7'h22, 7'h26, 7'h2b, 7'h2f,
        7'h33, 7'h38, 7'h3c, 7'h3f, 7'h43, 7'h47, 7'h4a, 7'h4d, 7'h50, 7'h53, 7'h56,
        7'h58, 7'h5a, 7'h5c, 7'h5e, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h64};

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] DAC_ADDR = 8'h08;
    localparam int CTRL_HOME_BIT = 0;
    localparam int CTRL_BRIDGE_EN_BIT = 1;
    localparam logic CTRL_BRIDGE_EN_RST = 1'b1;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        DECAY_SLOW = 2'h0, DECAY_FAST = 2'h1, DECAY_MIXED = 2'h2
    } mitc_decay_e;
    typedef enum logic [1:0] {
        CH_DRIVE = 2'b00, CH_FAST = 2'b01, CH_SLOW = 2'b11, CH_OFF = 2'b10
    } mitc_chop_e;
    typedef struct packed {
        logic out_pos_high;
        logic out_pos_low;
        logic out_neg_high;
        logic out_neg_low;
    } mitc_bridge_s;
    typedef struct packed {
        logic neg;
        logic [6:0] pct;
    } mitc_dac_s;
endpackage

/* File: mitc_step_ctrl.sv */
// step and direction controller model facing the indexer
`timescale 1ns/1ps

module mitc_step_ctrl #(
    parameter int SETUP_CYC = 65
) (
    input wire logic i_ref_clk,
    input wire logic i_req,
    input wire logic i_fwd,
    input wire logic i_ready,
    input wire logic [15:0] i_half,
    output logic o_step,
    output logic o_dir,
    output logic o_busy
);
    int cnt = 0;

    initial begin
        o_step = 1'b0;
        o_dir = 1'b0;
        o_busy = 1'b0;
    end

    // ----------------------------------------
    // one step pulse per request, direction held around it
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!o_busy && i_req && i_ready) begin
            o_busy <= 1'b1;
            o_dir <= i_fwd;
            cnt <= 0;
        end else if (o_busy) begin
            cnt <= cnt + 1;
            if (cnt == SETUP_CYC) begin
                o_step <= 1'b1;
            end
            if (cnt == SETUP_CYC + i_half) begin
                o_step <= 1'b0;
            end
            if (cnt == SETUP_CYC + 2 * i_half) begin
                o_busy <= 1'b0;
            end
        end
    end
endmodule

/* File: mitc_indexer_chopper_test.sv */
// self-checking bench for the microstep indexer and chopper
`timescale 1ns/1ps

module mitc_indexer_chopper_test;
    import mitc_pkg::*;
    localparam int WK = 20;
    logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, fwd = 1'b0, rdy = 1'b0, home_n = 1'b1;
    logic dlev = 1'b0, ddrv = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, lp_n = 1'b1;
    logic step, dir, busy, pready, pslverr, at_home_n, err;
    logic [2:0] res = 3'h0;
    logic [1:0][7:0] sense = '1, vref = '1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hd87a0147;
    logic [15:0] half = 16'd190;
    logic [6:0] idx = HOME_IDX;
    mitc_bridge_s [1:0] bridge;
    mitc_dac_s [1:0] dac;
    int n_errors = 0, checks_done = 0;

    always #5 clk = ~clk;

    mitc_indexer_chopper #(.WAKE_CYC(WK)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_step(step), .i_dir(dir), .i_resolution_select(res), .i_home_return_n(home_n),
        .i_low_power_request_n(lp_n), .i_decay_level(dlev), .i_decay_driven(ddrv),
        .i_winding_sense_pin(sense), .i_winding_reference_in(vref), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_bridge(bridge),
        .o_dac(dac), .o_at_home_n(at_home_n));

    mitc_step_ctrl ctl (.i_ref_clk(clk), .i_req(req), .i_fwd(fwd), .i_ready(rdy),
        .i_half(half), .o_step(step), .o_dir(dir), .o_busy(busy));

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [6:0] nxt(logic [6:0] i, logic [2:0] r, logic f);
        logic [7:0] s, o, v;
        s = (r > 3'h4) ? 8'h01 : (8'h20 >> r);
        o = (r == 3'h0) ? 8'h10 : 8'h00;
        v = {1'b0, i - o[6:0]};
        v = f ? (v / s + 8'h01) * s : ((v % s != 8'h00) ? v - v % s : v - s);
        return v[6:0] + o[6:0];
    endfunction

    function automatic mitc_dac_s lvl(logic [6:0] j);
        mitc_dac_s d;
        d.neg = j[6];
        d.pct = j[5] ? SINE_TBL[6'd32 - {1'b0, j[4:0]}] : SINE_TBL[j[4:0]];
        return d;
    endfunction

    function automatic logic [31:0] m(mitc_dac_s e, mitc_dac_s g);
        return (e.pct == 7'h00) ? {25'h0, g.pct} : {24'h0, g};
    endfunction

    // ----------------------------------------
    // checks and closing
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic hang(string nm);
        n_errors++;
        $display("[FAIL] %s expected done seen timeout", nm);
        complete_run();
    endtask

    // ----------------------------------------
    // bus and stimulus tasks
    // ----------------------------------------
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) hang("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic do_step(logic f, logic [2:0] r);
        int n;
        res <= r;
        fwd <= f;
        req <= 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) hang("step start");
        req <= 1'b0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) hang("step end");
    endtask

    task automatic cmp_pos();
        mitc_dac_s ea, eb;
        ea = lvl(idx + 7'h20);
        eb = lvl(idx);
        chk("dac a", m(ea, ea), m(ea, dac[0]));
        chk("dac b", m(eb, eb), m(eb, dac[1]));
        chk("home flag", {31'h0, idx != HOME_IDX}, {31'h0, at_home_n});
    endtask

    task automatic seg(int w, logic [3:0] p, output int n);
        n = 0;
        while (bridge[w] === p && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) hang("bridge phase");
    endtask

    task automatic wt(int w, logic [3:0] p);
        int n;
        seg(w, p, n);
        n = 0;
        while (bridge[w] !== p && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) hang("bridge wait");
    endtask

    task automatic chop(int w, logic [3:0] p2, logic [3:0] p3, int mid);
        int a, b, c;
        wt(w, 4'h9);
        seg(w, 4'h9, a);
        seg(w, p2, b);
        c = 0;
        if (p3 != p2) seg(w, p3, c);
        chk("blank", 1, 32'(a >= BLANK_CYC && a <= BLANK_CYC + 2));
        if (mid > 0) chk("mixed", 1, 32'(a + b >= mid - 1 && a + b <= mid + 1));
        chk("period", PWM_CYC, a + b + c);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] x;
        logic [2:0] r;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_pos();
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl", 32'h2, rd);
        apb(1'b1, DAC_ADDR, 32'hffff);
        apb(1'b0, DAC_ADDR, 32'h0);
        chk("dac reg", 32'h4747, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        repeat (WK) @(posedge clk);
        rdy <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            x = rnd();
            r = (k < 8) ? 3'(k) : x[2:0];
            half <= 16'd190 + {9'h0, x[10:4]};
            do_step(x[3], r);
            idx = nxt(idx, r, x[3]);
            cmp_pos();
            apb(1'b0, STATUS_ADDR, 32'h0);
            chk("status idx", {25'h0, idx}, {25'h0, rd[6:0]});
        end
        home_n <= 1'b0;
        do_step(1'b1, 3'h5);
        idx = HOME_IDX;
        cmp_pos();
        home_n <= 1'b1;
        do_step(1'b1, 3'h5);
        idx = 7'h11;
        cmp_pos();
        apb(1'b1, CTRL_ADDR, 32'h3);
        repeat (3) @(posedge clk);
        idx = HOME_IDX;
        cmp_pos();
        do_step(1'b1, 3'h5);
        idx = 7'h11;
        for (int d = 0; d < 3; d++) begin
            ddrv <= (d != 2);
            dlev <= (d == 1);
            apb(1'b0, STATUS_ADDR, 32'h0);
            chk("decay", d, {30'h0, rd[8:7]});
        end
        chop(0, 4'h6, 4'h5, MIXED_CYC);
        chop(1, 4'h5, 4'h5, 0);
        ddrv <= 1'b1;
        chop(0, 4'h5, 4'h5, 0);
        dlev <= 1'b1;
        chop(0, 4'h6, 4'h6, 0);
        wt(0, 4'h9);
        repeat (500) @(posedge clk);
        sense[0] <= 8'h00;
        repeat (4) @(posedge clk);
        chk("fast off", 32'h0, {28'h0, bridge[0]});
        sense[0] <= 8'hff;
        dlev <= 1'b0;
        do_step(1'b1, 3'h0);
        vref[0] <= 8'd100;
        wt(0, 4'h6);
        sense[0] <= 8'd14;
        repeat (1000) @(posedge clk);
        chk("below trip", 32'h6, {28'h0, bridge[0]});
        sense[0] <= 8'd15;
        repeat (4) @(posedge clk);
        chk("at trip", 32'h5, {28'h0, bridge[0]});
        apb(1'b1, CTRL_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        chk("bridge off", 32'h0, {28'h0, bridge[0]});
        apb(1'b1, CTRL_ADDR, 32'h2);
        wt(0, 4'h6);
        lp_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("sleep off", 32'h0, {28'h0, bridge[0]});
        lp_n <= 1'b1;
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("wake wait", 32'h0, {31'h0, rd[9]});
        repeat (WK) @(posedge clk);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("wake done", 32'h1, {31'h0, rd[9]});
        complete_run();
    end
endmodule
